// *** core_interrupt_and_cpu_status.sv ***
// Core interrupt flags, enables, vector selection and CPU status register.
// Assumes a core sequencer that accepts vectors and reports instruction events.
`timescale 1ns/10ps
`default_nettype none
module core_interrupt_and_cpu_status
(
    input wire logic clk, // Instruction-cycle clock.
    input wire logic rst_n, // Synchronous device reset, active low.
    input wire logic powerOnReset, // High with rst_n for a power-on reset.
    input wire logic brownOutReset, // High with rst_n for a brown-out reset.
    input wire logic brown_out_detect_enable, // Brown-out detector enabled.
    input wire logic [7:0] addr, // Register address.
    input wire logic [7:0] wrData, // Register write data.
    input wire logic wrEn, // Write strobe.
    input wire logic rdEn, // Read strobe.
    output logic [7:0] rdData, // Read data, valid the cycle after rdEn.
    input wire logic [7:0] peripheralFlags0, // First peripheral flag register.
    input wire logic [7:0] peripheralEnables0, // First peripheral enable register.
    input wire logic [7:0] peripheralFlags1, // Second peripheral flag register.
    input wire logic [7:0] peripheralEnables1, // Second peripheral enable register.
    input wire logic ext_count_pin, // External count pin.
    input wire logic countRisingSel, // Count pin edge select, high is rising.
    input wire logic extIrqPin, // External interrupt pin.
    input wire logic pinRisingSel, // Interrupt pin edge select, high is rising.
    input wire logic timerZeroOverflow, // One-cycle timer zero overflow pulse.
    input wire logic [3:0] stackPointer, // Stack pointer value.
    input wire logic watchdogTimeout, // Watchdog time-out pulse.
    input wire logic watchdog_clear_instr, // Watchdog clear instruction pulse.
    input wire logic sleepInstr, // Sleep instruction pulse.
    input wire logic vectorAck, // Core takes the offered vector.
    output logic vectorReq, // Vector request to the core.
    output logic [7:0] vectorAddr, // Vector address offered.
    output logic globalIrqDisable, // Current global disable bit.
    output logic stack_available // Current stack available bit.
);
    typedef enum logic [2:0]
    {
        IDLE = 3'b001,
        OFFER = 3'b010,
        SETTLE = 3'b100
    } vec_state_e;

    typedef struct packed
    {
        logic [7:0] irq;
        logic [7:0] cpu;
        logic [7:0] rd;
        logic [3:0] spPrev;
        logic req;
        logic [7:0] vec;
        vec_state_e state;
    } state_s;

    state_s st_q;
    state_s st_d;
    logic countEdge;
    logic pinEdge;
    logic [7:0] periFlags [core_irq_pkg::NUM_PERI_REGS];
    logic [7:0] periEnables [core_irq_pkg::NUM_PERI_REGS];
    logic [core_irq_pkg::NUM_PERI_REGS-1:0] periHit;

    edge_detect u_count_edge
    (
        .clk(clk),
        .rst_n(rst_n),
        .pin(ext_count_pin),
        .risingSel(countRisingSel),
        .edgeSeen(countEdge)
    );

    edge_detect u_pin_edge
    (
        .clk(clk),
        .rst_n(rst_n),
        .pin(extIrqPin),
        .risingSel(pinRisingSel),
        .edgeSeen(pinEdge)
    );

    assign periFlags[0] = peripheralFlags0;
    assign periFlags[1] = peripheralFlags1;
    assign periEnables[0] = peripheralEnables0;
    assign periEnables[1] = peripheralEnables1;

    generate
        for (genvar g = 0; g < core_irq_pkg::NUM_PERI_REGS; g++)
        begin : g_peri
            assign periHit[g] = |(periFlags[g] & periEnables[g]);
        end
    endgenerate

    function automatic logic [7:0] readReg(input logic [7:0] a, input logic [7:0] irqV,
                                           input logic [7:0] cpuV);
        begin
            if (a == core_irq_pkg::CPU_STATUS_CTRL_ADDR)
            begin
                readReg = cpuV & 8'h3F;
            end
            else if (a == core_irq_pkg::CORE_IRQ_STATUS_CTRL_ADDR)
            begin
                readReg = irqV;
            end
            else
            begin
                readReg = 8'h00;
            end
        end
    endfunction

    // Source flags in slots 3 to 0: peripheral, count pin, timer zero, external pin; slot 0 has top priority.
    function automatic logic [3:0] sourceFlags(input logic [7:0] irqV);
        begin
            sourceFlags = {irqV[core_irq_pkg::PEND_BIT], irqV[core_irq_pkg::CNT_FLAG_BIT],
                irqV[core_irq_pkg::TMR_FLAG_BIT], irqV[core_irq_pkg::PIN_FLAG_BIT]};
        end
    endfunction

    // Enable bits in the same slots as sourceFlags.
    function automatic logic [3:0] sourceEnables(input logic [7:0] irqV);
        begin
            sourceEnables = {irqV[core_irq_pkg::PERI_EN_BIT], irqV[core_irq_pkg::CNT_EN_BIT],
                irqV[core_irq_pkg::TMR_EN_BIT], irqV[core_irq_pkg::PIN_EN_BIT]};
        end
    endfunction

    logic [3:0] arriving;
    logic peripheralPending;
    logic [7:0] enDropped;
    logic [3:0] request;

    always_comb
    begin
        st_d = st_q;
        enDropped = 8'h00;
        peripheralPending = |periHit;
        // Events landing now count as set flags for the enable-drop trap.
        arriving = {peripheralPending, countEdge, timerZeroOverflow, pinEdge};
        st_d.irq[core_irq_pkg::PEND_BIT] = peripheralPending;
        // Software writes; only enables and flag bits 6..4 are writable here.
        if (wrEn && addr == core_irq_pkg::CORE_IRQ_STATUS_CTRL_ADDR)
        begin
            st_d.irq[6:0] = wrData[6:0];
            enDropped[3:0] = sourceEnables(st_q.irq) & ~sourceEnables(wrData);
        end
        if (wrEn && addr == core_irq_pkg::CPU_STATUS_CTRL_ADDR)
        begin
            st_d.cpu = (st_q.cpu & ~core_irq_pkg::CPU_WRITE_MASK)
                | (wrData & core_irq_pkg::CPU_WRITE_MASK);
        end
        // Hardware sets win over software clears.
        if (countEdge)
        begin
            st_d.irq[core_irq_pkg::CNT_FLAG_BIT] = 1'b1;
        end
        if (timerZeroOverflow)
        begin
            st_d.irq[core_irq_pkg::TMR_FLAG_BIT] = 1'b1;
        end
        if (pinEdge)
        begin
            st_d.irq[core_irq_pkg::PIN_FLAG_BIT] = 1'b1;
        end
        // Stack, watchdog time-out and power-down status.
        st_d.spPrev = stackPointer;
        if (stackPointer == core_irq_pkg::STACK_TOP
            || (st_q.spPrev == core_irq_pkg::STACK_TOP && stackPointer == 4'h0))
        begin
            st_d.cpu[core_irq_pkg::STACK_BIT] = 1'b0;
        end
        if (watchdogTimeout)
        begin
            st_d.cpu[core_irq_pkg::WDTO_BIT] = 1'b0;
        end
        else if (watchdog_clear_instr || sleepInstr)
        begin
            st_d.cpu[core_irq_pkg::WDTO_BIT] = 1'b1;
        end
        if (sleepInstr)
        begin
            st_d.cpu[core_irq_pkg::PWRDN_BIT] = 1'b0;
        end
        else if (watchdog_clear_instr)
        begin
            st_d.cpu[core_irq_pkg::PWRDN_BIT] = 1'b1;
        end
        // Request vector per source, gated by enables and the global disable.
        request = sourceFlags(st_q.irq) & sourceEnables(st_q.irq);
        case (st_q.state)
            IDLE:
            begin
                if (!st_q.cpu[core_irq_pkg::GDIS_BIT])
                begin
                    if (|(enDropped[3:0] & (sourceFlags(st_q.irq) | arriving)))
                    begin
                        st_d.vec = core_irq_pkg::VEC_RESET;
                        st_d.req = 1'b1;
                        st_d.state = OFFER;
                    end
                    else if (request[0])
                    begin
                        st_d.vec = core_irq_pkg::VEC_PIN;
                        st_d.req = 1'b1;
                        st_d.state = OFFER;
                    end
                    else if (request[1])
                    begin
                        st_d.vec = core_irq_pkg::VEC_TMR;
                        st_d.req = 1'b1;
                        st_d.state = OFFER;
                    end
                    else if (request[2])
                    begin
                        st_d.vec = core_irq_pkg::VEC_CNT;
                        st_d.req = 1'b1;
                        st_d.state = OFFER;
                    end
                    else if (request[3])
                    begin
                        st_d.vec = core_irq_pkg::VEC_PERI;
                        st_d.req = 1'b1;
                        st_d.state = OFFER;
                    end
                end
            end
            OFFER:
            begin
                if (vectorAck)
                begin
                    st_d.req = 1'b0;
                    st_d.state = SETTLE;
                    // Taken pin, timer or count vector clears its own flag unless a new event set it now.
                    if (st_q.vec == core_irq_pkg::VEC_PIN && !pinEdge)
                    begin
                        st_d.irq[core_irq_pkg::PIN_FLAG_BIT] = 1'b0;
                    end
                    if (st_q.vec == core_irq_pkg::VEC_TMR && !timerZeroOverflow)
                    begin
                        st_d.irq[core_irq_pkg::TMR_FLAG_BIT] = 1'b0;
                    end
                    if (st_q.vec == core_irq_pkg::VEC_CNT && !countEdge)
                    begin
                        st_d.irq[core_irq_pkg::CNT_FLAG_BIT] = 1'b0;
                    end
                end
            end
            SETTLE:
            begin
                st_d.state = IDLE;
            end
            default:
            begin
                st_d.state = IDLE;
                st_d.req = 1'b0;
            end
        endcase
        st_d.rd = rdEn ? readReg(addr, st_q.irq, st_q.cpu) : 8'h00;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q.irq <= core_irq_pkg::IRQ_RESET;
            // Every reset clears the power-on bit; power-on, or brown-out with the detector enabled, clears the brown-out bit.
            if (powerOnReset)
            begin
                st_q.cpu <= core_irq_pkg::CPU_RESET_POWERON;
            end
            else
            begin
                st_q.cpu <= core_irq_pkg::CPU_RESET;
            end
            if (brownOutReset && brown_out_detect_enable)
            begin
                st_q.cpu[core_irq_pkg::BOR_BIT] <= 1'b0;
            end
            st_q.rd <= 8'h00;
            st_q.spPrev <= 4'h0;
            st_q.req <= 1'b0;
            st_q.vec <= core_irq_pkg::VEC_RESET;
            st_q.state <= IDLE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign rdData = st_q.rd;
    assign vectorReq = st_q.req;
    assign vectorAddr = st_q.vec;
    assign globalIrqDisable = st_q.cpu[core_irq_pkg::GDIS_BIT];
    assign stack_available = st_q.cpu[core_irq_pkg::STACK_BIT];
endmodule
`default_nettype wire

// *** core_irq_pkg.sv ***
// Constants shared by the core interrupt and CPU status logic.
// Assumes an 8-bit register port and a single clock domain.
package core_irq_pkg;
    localparam logic [7:0] CPU_STATUS_CTRL_ADDR = 8'h06;
    localparam logic [7:0] CORE_IRQ_STATUS_CTRL_ADDR = 8'h07;
    // Bit positions in the interrupt status/control register.
    localparam int PEND_BIT = 7;
    localparam int CNT_FLAG_BIT = 6;
    localparam int TMR_FLAG_BIT = 5;
    localparam int PIN_FLAG_BIT = 4;
    localparam int PERI_EN_BIT = 3;
    localparam int CNT_EN_BIT = 2;
    localparam int TMR_EN_BIT = 1;
    localparam int PIN_EN_BIT = 0;
    // Bit positions in the CPU status register.
    localparam int STACK_BIT = 5;
    localparam int GDIS_BIT = 4;
    localparam int WDTO_BIT = 3;
    localparam int PWRDN_BIT = 2;
    localparam int POR_BIT = 1;
    localparam int BOR_BIT = 0;
    localparam logic [7:0] IRQ_RESET = 8'h00;
    localparam logic [7:0] CPU_RESET = 8'h3D;
    localparam logic [7:0] CPU_RESET_POWERON = 8'h3C;
    localparam logic [7:0] CPU_WRITE_MASK = 8'h13;
    // Vector addresses.
    localparam logic [7:0] VEC_RESET = 8'h00;
    localparam logic [7:0] VEC_PIN = 8'h08;
    localparam logic [7:0] VEC_TMR = 8'h10;
    localparam logic [7:0] VEC_CNT = 8'h18;
    localparam logic [7:0] VEC_PERI = 8'h20;
    localparam logic [3:0] STACK_TOP = 4'hF;
    localparam int NUM_PERI_REGS = 2;
endpackage

// *** edge_detect.sv ***
// Pin synchroniser with a selectable edge detector.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module edge_detect
(
    input wire logic clk, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic pin, // Asynchronous pin.
    input wire logic risingSel, // High selects the rising edge.
    output logic edgeSeen // One-cycle pulse on the chosen edge.
);
    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
        logic [1:0] fill;
    } sync_s;
    sync_s st_q;
    sync_s st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.s1 = pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // Edges are held off until all three stages hold the real pin level.
        if (st_q.fill != 2'h3)
        begin
            st_d.fill = st_q.fill + 2'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign edgeSeen = (st_q.fill == 2'h3)
        && (risingSel ? (st_q.s2 & ~st_q.s3) : (~st_q.s2 & st_q.s3));
endmodule
`default_nettype wire

// *** core_irq_checker.sv ***
// Port assertions for the core interrupt and CPU status block.
// Bound to the top module; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module core_irq_checker
(
    input wire logic clk, // Clock.
    input wire logic rst_n, // Reset.
    input wire logic [7:0] addr, // Address.
    input wire logic rdEn, // Read strobe.
    input wire logic [7:0] rdData, // Read data.
    input wire logic [3:0] stackPointer, // Stack pointer.
    input wire logic vectorAck, // Vector taken.
    input wire logic vectorReq, // Vector offered.
    input wire logic [7:0] vectorAddr, // Vector address.
    input wire logic globalIrqDisable, // Global disable.
    input wire logic stack_available // Stack bit.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_wait; vectorReq && !vectorAck; endsequence
    sequence s_held; vectorReq && $stable(vectorAddr); endsequence
    sequence s_taken; vectorReq && vectorAck; endsequence
    property p_hold; s_wait |=> s_held; endproperty
    a_hold: assert property (p_hold) else $error("offer changed before ack");
    property p_drop; s_taken |=> !vectorReq; endproperty
    a_drop: assert property (p_drop) else $error("offer kept after ack");
    property p_addr; vectorReq |-> vectorAddr inside {8'h00, 8'h08, 8'h10, 8'h18, 8'h20}; endproperty
    a_addr: assert property (p_addr) else $error("bad vector address");
    property p_mask; globalIrqDisable && !vectorReq |=> !vectorReq; endproperty
    a_mask: assert property (p_mask) else $error("vector while disabled");
    property p_stack; stackPointer == 4'hF |=> !stack_available; endproperty
    a_stack: assert property (p_stack) else $error("stack bit kept at top");
    property p_stick; !stack_available |=> !stack_available; endproperty
    a_stick: assert property (p_stick) else $error("stack bit set without reset");
    property p_idle; !rdEn |=> rdData == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data outside slot");
    property p_rd06;
        rdEn && addr == 8'h06 |=> rdData[7:6] == 2'b00 && rdData[5] == $past(stack_available)
            && rdData[4] == $past(globalIrqDisable);
    endproperty
    a_rd06: assert property (p_rd06) else $error("status read mismatch");
endmodule
bind core_interrupt_and_cpu_status core_irq_checker core_irq_checker_inst
(
    .clk, .rst_n, .addr, .rdEn, .rdData, .stackPointer, .vectorAck, .vectorReq,
    .vectorAddr, .globalIrqDisable, .stack_available
);
`default_nettype wire

// *** core_seq_model.sv ***
// Behavioural core sequencer that takes offered interrupt vectors.
// Assumes the offer stands until the acknowledge is sampled.
`timescale 1ns/10ps
`default_nettype none
module core_seq_model
(
    input wire logic clk, // Clock.
    input wire logic rst_n, // Reset.
    input wire logic vectorReq, // Vector offered.
    input wire logic [3:0] ackDelay, // Cycles before taking it.
    output logic vectorAck // One-cycle acceptance.
);
    logic [3:0] waitCount_q;
    always_ff @(posedge clk)
    begin
        if (!rst_n || vectorAck)
        begin
            waitCount_q <= 4'h0;
            vectorAck <= 1'b0;
        end
        else if (vectorReq && waitCount_q == ackDelay)
            vectorAck <= 1'b1;
        else if (vectorReq)
            waitCount_q <= waitCount_q + 4'h1;
    end
endmodule
`default_nettype wire

// *** core_interrupt_and_cpu_status_bench.sv ***
// Self-checking bench for the core interrupt and CPU status block.
// Drives the register port, event pulses and pins; a core model takes vectors.
`timescale 1ns/10ps
`default_nettype none
module core_interrupt_and_cpu_status_bench;
    logic clk = 1'b0, rst_n = 1'b0, powerOnReset = 1'b1, brownOutReset = 1'b0;
    logic brown_out_detect_enable = 1'b1, wrEn = 1'b0, rdEn = 1'b0;
    logic [7:0] addr = 8'h00, wrData = 8'h00, rdData, vectorAddr;
    logic [7:0] peripheralFlags0 = 8'h00, peripheralEnables0 = 8'h00;
    logic [7:0] peripheralFlags1 = 8'h00, peripheralEnables1 = 8'h01;
    logic ext_count_pin = 1'b1, countRisingSel = 1'b0, extIrqPin = 1'b0, pinRisingSel = 1'b1;
    logic timerZeroOverflow = 1'b0, watchdogTimeout = 1'b0, watchdog_clear_instr = 1'b0;
    logic sleepInstr = 1'b0, vectorAck, vectorReq, globalIrqDisable, stack_available;
    logic [3:0] stackPointer = 4'h0, ackDelay = 4'h0;
    logic [7:0] enTab [4] = '{8'h01, 8'h02, 8'h04, 8'h08};
    logic [7:0] vecTab [4] = '{8'h08, 8'h10, 8'h18, 8'h20};
    int nFail = 0;
    int compares = 0;
    core_interrupt_and_cpu_status core_interrupt_and_cpu_status_inst
    (
        .clk, .rst_n, .powerOnReset, .brownOutReset, .brown_out_detect_enable, .addr,
        .wrData, .wrEn, .rdEn, .rdData, .peripheralFlags0, .peripheralEnables0,
        .peripheralFlags1, .peripheralEnables1, .ext_count_pin, .countRisingSel, .extIrqPin,
        .pinRisingSel, .timerZeroOverflow, .stackPointer, .watchdogTimeout,
        .watchdog_clear_instr, .sleepInstr, .vectorAck, .vectorReq, .vectorAddr,
        .globalIrqDisable, .stack_available
    );
    core_seq_model core_seq_model_inst (.clk, .rst_n, .vectorReq, .ackDelay, .vectorAck);
    initial forever #2.5 clk = ~clk;
    task giveVerdict;
        $display("compares %0d failures %0d", compares, nFail);
        if (nFail == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task ck(input logic [7:0] e, input logic [7:0] g, input string nm);
        compares++;
        if (g !== e)
        begin
            nFail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge clk);
        wrEn <= 1'b0;
    endtask
    task rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk);
        rdEn <= 1'b0;
        #1 ck(e, rdData & m, "rdData");
    endtask
    task waitReq(input logic v);
        int i;
        i = 0;
        #1;
        while (vectorReq !== v)
        begin
            @(posedge clk);
            #1 i++;
            if (i > 20)
            begin
                nFail++;
                giveVerdict;
            end
        end
    endtask
    task vw(input logic [7:0] e);
        waitReq(1'b1);
        ck(e, vectorAddr, "vectorAddr");
        waitReq(1'b0);
    endtask
    task trig(input int s);
        @(posedge clk);
        extIrqPin <= (s == 0);
        timerZeroOverflow <= (s == 1);
        ext_count_pin <= (s != 2);
        if (s == 3)
            peripheralFlags1 <= 8'h01;
        @(posedge clk);
        extIrqPin <= 1'b0;
        timerZeroOverflow <= 1'b0;
        ext_count_pin <= 1'b1;
    endtask
    task pulse(input int s);
        @(posedge clk);
        watchdogTimeout <= (s == 0);
        watchdog_clear_instr <= (s == 1);
        sleepInstr <= (s == 2);
        @(posedge clk);
        {watchdogTimeout, watchdog_clear_instr, sleepInstr} <= 3'b000;
    endtask
    task testRegs;
        rc(8'h06, 8'hFF, 8'h3C);
        rc(8'h07, 8'hFF, 8'h00);
        rc(8'h08, 8'hFF, 8'h00);
        wr(8'h06, 8'hFF);
        rc(8'h06, 8'hFF, 8'h3F);
        wr(8'h07, 8'hFF);
        rc(8'h07, 8'hFF, 8'h7F);
        wr(8'h07, 8'h00);
        wr(8'h06, 8'h00);
        rc(8'h06, 8'hFF, 8'h2C);
        @(posedge clk);
        stackPointer <= 4'hF;
        rc(8'h06, 8'h20, 8'h00);
        @(posedge clk);
        stackPointer <= 4'h0;
        rc(8'h06, 8'h20, 8'h00);
        pulse(0);
        rc(8'h06, 8'h0C, 8'h04);
        pulse(1);
        rc(8'h06, 8'h0C, 8'h0C);
        pulse(2);
        rc(8'h06, 8'h0C, 8'h08);
        $display("done registers");
    endtask
    task testResets;
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk);
            rst_n <= 1'b0;
            powerOnReset <= (k == 1);
            brownOutReset <= (k == 2);
            repeat (4) @(posedge clk);
            rst_n <= 1'b1;
            powerOnReset <= 1'b0;
            brownOutReset <= 1'b0;
            rc(8'h06, 8'hFF, (k == 0) ? 8'h3D : 8'h3C);
        end
        $display("done resets");
    endtask
    task testMask;
        wr(8'h07, 8'h03);
        trig(1);
        trig(0);
        repeat (6) @(posedge clk);
        #1 ck(8'h00, {7'h00, vectorReq}, "vectorReq");
        rc(8'h07, 8'hFF, 8'h33);
        wr(8'h06, 8'h00);
        vw(8'h08);
        vw(8'h10);
        @(posedge clk);
        timerZeroOverflow <= 1'b1;
        @(posedge clk);
        timerZeroOverflow <= 1'b0;
        addr <= 8'h07;
        wrData <= 8'h01;
        wrEn <= 1'b1;
        @(posedge clk);
        wrEn <= 1'b0;
        vw(8'h00);
        wr(8'h07, 8'h00);
        $display("done masking");
    endtask
    task testVectors;
        peripheralFlags0 <= 8'h02;
        peripheralEnables0 <= 8'h02;
        repeat (4) @(posedge clk);
        #1 ck(8'h00, {7'h00, vectorReq}, "vectorReq");
        rc(8'h07, 8'h80, 8'h80);
        @(posedge clk);
        peripheralEnables0 <= 8'h00;
        rc(8'h07, 8'h80, 8'h00);
        @(posedge clk);
        peripheralFlags0 <= 8'h00;
        for (int s = 0; s < 4; s++)
        begin
            ackDelay <= 4'(s);
            wr(8'h07, enTab[s]);
            trig(s);
            vw(vecTab[s]);
            rc(8'h07, 8'h7F, enTab[s]);
        end
        rc(8'h07, 8'h80, 8'h80);
        @(posedge clk);
        peripheralFlags1 <= 8'h00;
        wr(8'h06, 8'h10);
        repeat (8) @(posedge clk);
        rc(8'h07, 8'h80, 8'h00);
        $display("done vectors");
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        powerOnReset <= 1'b0;
        testRegs;
        testResets;
        testMask;
        testVectors;
        giveVerdict;
    end
endmodule
`default_nettype wire
